// File: rtl/zvfs_pkg.sv
// Package for the soft-switch flag and start-up sequencer block.
// Assumes a 250 MHz clock; all times are converted to cycles here.
package zvfs_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Flag pulse delay and width, in nanoseconds
  localparam int unsigned FLAG_DELAY_NS = 20;
  localparam int unsigned FLAG_WIDTH_NS = 40;

  // Least times round up to whole cycles
  localparam int unsigned FLAG_DELAY_CYC = (FLAG_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned FLAG_WIDTH_CYC = (FLAG_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Minimum reverse-conduction time per drive-strength setting, in ns
  localparam int unsigned MIN_REV_NS_S0 = 40;
  localparam int unsigned MIN_REV_NS_S1 = 28;
  localparam int unsigned MIN_REV_NS_S2 = 20;
  localparam int unsigned MIN_REV_NS_S3 = 12;

  // Same thresholds in cycles, rounded up
  localparam int unsigned MIN_REV_CYC_S0 = (MIN_REV_NS_S0 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MIN_REV_CYC_S1 = (MIN_REV_NS_S1 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MIN_REV_CYC_S2 = (MIN_REV_NS_S2 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MIN_REV_CYC_S3 = (MIN_REV_NS_S3 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Counter width for all timers
  localparam int unsigned CNT_W = 8;

  // Start-up sequencer states, one-hot
  typedef enum logic [2:0] {
    ZVFS_ST_WAIT_SUPPLY = 3'b001,
    ZVFS_ST_RAILS_BUILD = 3'b010,
    ZVFS_ST_RUN = 3'b100
  } zvfs_start_state_type;

  // Flag pulse states, one-hot
  typedef enum logic [2:0] {
    ZVFS_FL_IDLE = 3'b001,
    ZVFS_FL_DELAY = 3'b010,
    ZVFS_FL_PULSE = 3'b100
  } zvfs_flag_state_type;

  // Supply and rail monitor inputs travelling together
  typedef struct packed {
    logic above_rise_thr; // Supply above rising lockout threshold
    logic below_fall_thr; // Supply below falling lockout threshold
    logic rail_5v_ready; // Internal 5 V rail ready
    logic neg_rail_ready; // Negative gate rail ready
  } zvfs_supply_type;

endpackage

// File: rtl/zvfs_top.sv
// Soft-switch flag detector and start-up sequencer of a driven power switch.
// Assumes all inputs are synchronous to clk; comparators are external inputs.
// Operation
// - Sample negative drain on gate rising edge
// - Confirmed: delay, then fixed-width flag pulse
// - Short reverse conduction gives no flag
// - Hard switching gives no flag
// - Detection time depends on drive strength
// - Each cycle judged on its own unless a flag is still pending
// - Fault held low while supply builds
// - Rails build above rise, pause below fall
// - Both rails ready: release fault, follow gate
`timescale 1ns/100ps
module zvfs_top #(
  parameter int unsigned DELAY_CYC = zvfs_pkg::FLAG_DELAY_CYC,
  parameter int unsigned WIDTH_CYC = zvfs_pkg::FLAG_WIDTH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic gate_cmd_in,
  input wire logic drain_negative_in,
  input wire logic [1:0] drive_strength,
  input wire zvfs_pkg::zvfs_supply_type supply_in,
  output logic rail_build_en,
  output logic gate_drive_out,
  output logic fault_n_out,
  output logic fault_n_oe_n,
  output logic zero_volt_flag_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Sequencer state
  zvfs_pkg::zvfs_start_state_type start_state_reg;
  // Flag pulse state
  zvfs_pkg::zvfs_flag_state_type flag_state_reg;
  // Previous gate command, for edge detection
  logic gate_prev_reg;
  // Reverse-conduction length counter, saturating
  logic [zvfs_pkg::CNT_W-1:0] rev_cnt_reg;
  // Flag delay and width timer
  logic [zvfs_pkg::CNT_W-1:0] flag_cnt_reg;
  // Registered fault level
  logic fault_n_reg;
  // Registered gate drive
  logic gate_drive_reg;
  // Registered flag level
  logic flag_reg;
  // Gate rising edge seen this cycle
  logic gate_rise;
  // Reverse conduction long enough
  logic rev_long_enough;
  // Sequencer in normal run
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Detection threshold in cycles for a drive-strength code
  // Faster drive settings need a shorter reverse stretch
  function automatic logic [zvfs_pkg::CNT_W-1:0] min_rev_cycles(input logic [1:0] sel);
    logic [zvfs_pkg::CNT_W-1:0] val;
    val = '0;
    case (sel)
      2'h0: val = zvfs_pkg::CNT_W'(zvfs_pkg::MIN_REV_CYC_S0);
      2'h1: val = zvfs_pkg::CNT_W'(zvfs_pkg::MIN_REV_CYC_S1);
      2'h2: val = zvfs_pkg::CNT_W'(zvfs_pkg::MIN_REV_CYC_S2);
      default: val = zvfs_pkg::CNT_W'(zvfs_pkg::MIN_REV_CYC_S3);
    endcase
    return val;
  endfunction

  // Sequencer has released the switch
  assign running = (start_state_reg == zvfs_pkg::ZVFS_ST_RUN);
  // Rising edge of gate command
  assign gate_rise = gate_cmd_in & ~gate_prev_reg;
  // Conduction must reach the strength-dependent time
  assign rev_long_enough = (rev_cnt_reg >= min_rev_cycles(drive_strength));

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer

  // Lockout, rail build-up and release
  // A supply dip only matters while rails build; run is kept until reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_state_reg <= zvfs_pkg::ZVFS_ST_WAIT_SUPPLY;
    end else if (clk_en) begin
      case (start_state_reg)
        // Supply still building
        zvfs_pkg::ZVFS_ST_WAIT_SUPPLY: begin
          if (supply_in.above_rise_thr) begin
            start_state_reg <= zvfs_pkg::ZVFS_ST_RAILS_BUILD;
          end
        end
        // Rails building; pause on supply dip
        zvfs_pkg::ZVFS_ST_RAILS_BUILD: begin
          if (supply_in.below_fall_thr) begin
            start_state_reg <= zvfs_pkg::ZVFS_ST_WAIT_SUPPLY;
          end else if (supply_in.rail_5v_ready && supply_in.neg_rail_ready) begin
            start_state_reg <= zvfs_pkg::ZVFS_ST_RUN;
          end
        end
        // Normal switching
        zvfs_pkg::ZVFS_ST_RUN: begin
          start_state_reg <= zvfs_pkg::ZVFS_ST_RUN;
        end
        default: begin
          start_state_reg <= zvfs_pkg::ZVFS_ST_WAIT_SUPPLY;
        end
      endcase
    end
  end

  // Rails build only in the build state
  // Low in lockout and once running
  assign rail_build_en = (start_state_reg == zvfs_pkg::ZVFS_ST_RAILS_BUILD);

  // Fault output: low until running
  // Registered so the pin never glitches high on a state change
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_n_reg <= 1'b0;
    end else if (clk_en) begin
      fault_n_reg <= running;
    end
  end

  // Open-drain: enable low pulls the pin low
  assign fault_n_out = 1'b0;
  assign fault_n_oe_n = fault_n_reg;

  // Gate drive follows command only when running
  // Command is ignored while the sequencer holds the fault low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_drive_reg <= 1'b0;
    end else if (clk_en) begin
      gate_drive_reg <= running & gate_cmd_in;
    end
  end
  assign gate_drive_out = gate_drive_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Soft-switch detector

  // Gate edge history
  // Resets to the idle low level, so no false edge after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_prev_reg <= 1'b0;
    end else if (clk_en) begin
      gate_prev_reg <= gate_cmd_in;
    end
  end

  // Length of current negative-drain stretch while gate is low
  // Any positive drain sample restarts the count; saturates at all ones
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rev_cnt_reg <= '0;
    end else if (clk_en) begin
      if (gate_cmd_in || !drain_negative_in) begin
        rev_cnt_reg <= '0;
      end else if (rev_cnt_reg != '1) begin
        rev_cnt_reg <= rev_cnt_reg + 1'b1;
      end
    end
  end

  // Delay then pulse on a confirmed soft switch
  // Gate edges during a pending delay or pulse are ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_state_reg <= zvfs_pkg::ZVFS_FL_IDLE;
      flag_cnt_reg <= '0;
      flag_reg <= 1'b0;
    end else if (clk_en) begin
      case (flag_state_reg)
        // Wait for gate edge with enough reverse conduction
        zvfs_pkg::ZVFS_FL_IDLE: begin
          flag_reg <= 1'b0;
          if (gate_rise && running && drain_negative_in && rev_long_enough) begin
            flag_state_reg <= zvfs_pkg::ZVFS_FL_DELAY;
            flag_cnt_reg <= zvfs_pkg::CNT_W'(DELAY_CYC - 1);
          end
        end
        // Count out the delay
        zvfs_pkg::ZVFS_FL_DELAY: begin
          if (!running) begin
            flag_state_reg <= zvfs_pkg::ZVFS_FL_IDLE;
          end else if (flag_cnt_reg == '0) begin
            flag_state_reg <= zvfs_pkg::ZVFS_FL_PULSE;
            flag_cnt_reg <= zvfs_pkg::CNT_W'(WIDTH_CYC - 1);
            flag_reg <= 1'b1;
          end else begin
            flag_cnt_reg <= flag_cnt_reg - 1'b1;
          end
        end
        // Hold the flag for the pulse width
        zvfs_pkg::ZVFS_FL_PULSE: begin
          if (flag_cnt_reg == '0 || !running) begin
            flag_state_reg <= zvfs_pkg::ZVFS_FL_IDLE;
            flag_reg <= 1'b0;
          end else begin
            flag_cnt_reg <= flag_cnt_reg - 1'b1;
          end
        end
        default: begin
          flag_state_reg <= zvfs_pkg::ZVFS_FL_IDLE;
          flag_reg <= 1'b0;
        end
      endcase
    end
  end

  // Flag pin straight from its flip-flop
  assign zero_volt_flag_out = flag_reg;

endmodule

// File: verification/zvfs_chk.sv
// Port checker for zvfs_top.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/100ps
module zvfs_chk #(
  parameter int unsigned DELAY_CYC = 1,
  parameter int unsigned WIDTH_CYC = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic gate_cmd_in,
  input wire logic drain_negative_in,
  input wire logic [1:0] drive_strength,
  input wire zvfs_pkg::zvfs_supply_type supply_in,
  input wire logic rail_build_en,
  input wire logic gate_drive_out,
  input wire logic fault_n_out,
  input wire logic fault_n_oe_n,
  input wire logic zero_volt_flag_out
);
  localparam int unsigned LAG = DELAY_CYC + 1; // Taking edge to first sample of a high flag
  logic [7:0] hi_cnt; // Flag high length
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Count cycles the flag stays high
  always_ff @(posedge clk) begin
    hi_cnt <= zero_volt_flag_out ? hi_cnt + 8'h01 : 8'h00;
  end
  ////////////////////////////////////////////////////////////
  rst_out_a: assert property (disable iff (1'b0) !rst_n |=> !fault_n_oe_n && !zero_volt_flag_out
    && !gate_drive_out && !rail_build_en) else $error("outputs active after reset");
  drain_low_a: assert property (fault_n_out == 1'b0) else $error("fault data not low");
  flag_quiet_a: assert property (!fault_n_oe_n |-> !zero_volt_flag_out) else $error("flag in start-up");
  build_gate_a: assert property (rail_build_en |-> !gate_drive_out && !fault_n_oe_n)
    else $error("drive during build");
  build_start_a: assert property ($rose(rail_build_en) |-> $past(supply_in.above_rise_thr))
    else $error("build without supply");
  build_pause_a: assert property (rail_build_en && clk_en && supply_in.below_fall_thr |=> !rail_build_en)
    else $error("build not paused");
  fault_release_a: assert property (rail_build_en && clk_en && !supply_in.below_fall_thr
    && supply_in.rail_5v_ready && supply_in.neg_rail_ready |=> !fault_n_oe_n ##1 fault_n_oe_n)
    else $error("fault release late");
  fault_hold_a: assert property (fault_n_oe_n |=> fault_n_oe_n) else $error("fault reasserted");
  drive_follow_a: assert property (fault_n_oe_n && clk_en |=> gate_drive_out == $past(gate_cmd_in))
    else $error("drive not following");
  flag_width_a: assert property ($fell(zero_volt_flag_out) && $past(rst_n) |-> hi_cnt == WIDTH_CYC)
    else $error("flag width wrong");
  flag_cause_a: assert property ($rose(zero_volt_flag_out) |-> $past(gate_cmd_in, LAG)
    && !$past(gate_cmd_in, LAG + 1) && $past(drain_negative_in, LAG)) else $error("flag without cause");
endmodule
bind zvfs_top zvfs_chk #(.DELAY_CYC(DELAY_CYC), .WIDTH_CYC(WIDTH_CYC)) u_zvfs_chk (.clk(clk), .rst_n(rst_n),
  .clk_en(clk_en), .gate_cmd_in(gate_cmd_in), .drain_negative_in(drain_negative_in),
  .drive_strength(drive_strength), .supply_in(supply_in), .rail_build_en(rail_build_en),
  .gate_drive_out(gate_drive_out), .fault_n_out(fault_n_out), .fault_n_oe_n(fault_n_oe_n),
  .zero_volt_flag_out(zero_volt_flag_out));

// File: verification/zvfs_ctrl_model.sv
// Converter controller model: gate command and drain comparator.
// Driven by bench task calls, changes after clk rising edges.
`timescale 1ns/100ps
module zvfs_ctrl_model (
  input wire logic clk,
  output logic gate_cmd,
  output logic drain_neg
);
  initial begin
    gate_cmd = 1'b0;
    drain_neg = 1'b0;
  end
  // Reverse conduction, turn-on for 4 cycles, then idle
  task automatic run_cycle(input int rev, input logic neg_edge);
    repeat (rev) begin
      @(posedge clk);
      drain_neg <= 1'b1;
    end
    @(posedge clk);
    gate_cmd <= 1'b1;
    drain_neg <= neg_edge;
    repeat (4) @(posedge clk);
    gate_cmd <= 1'b0;
    drain_neg <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
endmodule

// File: verification/tb_zvfs_top.sv
// Bench for zvfs_top with a controller model.
// 250 MHz clock; flag delay and width shortened.
`timescale 1ns/100ps
module tb_zvfs_top;
  localparam int unsigned WID = 3; // Flag width used
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strength = 2'h0;
  logic en = 1'b1; // Clock enable
  zvfs_pkg::zvfs_supply_type sup = 4'h0;
  logic gate, dneg, build, gdrv, flt, flt_oe_n, flag;
  int bad_count = 0;
  int n_checks = 0;
  int flag_hi = 0; // Flag high cycles
  int gd_hi = 0; // Drive high cycles
  int thr [4] = '{zvfs_pkg::MIN_REV_CYC_S0, zvfs_pkg::MIN_REV_CYC_S1, // Detection cycles per code
    zvfs_pkg::MIN_REV_CYC_S2, zvfs_pkg::MIN_REV_CYC_S3};
  always #2 clk = ~clk;
  // Tally high cycles at the falling edge, where outputs are settled
  always @(negedge clk) begin
    if (flag === 1'b1) flag_hi++;
    if (gdrv === 1'b1) gd_hi++;
  end
  zvfs_ctrl_model u_zvfs_ctrl_model (.clk(clk), .gate_cmd(gate), .drain_neg(dneg));
  zvfs_top #(.DELAY_CYC(2), .WIDTH_CYC(WID)) u_zvfs_top (.clk(clk), .rst_n(rst_n), .clk_en(en),
    .gate_cmd_in(gate), .drain_negative_in(dneg), .drive_strength(strength), .supply_in(sup),
    .rail_build_en(build), .gate_drive_out(gdrv), .fault_n_out(flt), .fault_n_oe_n(flt_oe_n),
    .zero_volt_flag_out(flag));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Lockout, pause with rails ready, release
  task automatic t_startup();
    u_zvfs_ctrl_model.run_cycle(thr[0], 1'b1);
    #1 check(8'(flag_hi + gd_hi), 8'h00);
    check({6'h0, flt, flt_oe_n}, 8'h00);
    @(posedge clk) sup <= 4'h8;
    repeat (2) @(posedge clk);
    #1 check({7'h0, build}, 8'h01);
    @(posedge clk) sup <= 4'h7;
    repeat (3) @(posedge clk);
    #1 check({6'h0, build, flt_oe_n}, 8'h00);
    @(posedge clk) sup <= 4'hb;
    repeat (3) @(posedge clk);
    #1 check({7'h0, flt_oe_n}, 8'h01);
    gd_hi = 0;
    u_zvfs_ctrl_model.run_cycle(0, 1'b0);
    #1 check(8'(gd_hi), 8'h04);
  endtask
  // Each strength code at and below its threshold
  task automatic t_strength();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) strength <= 2'(s);
      #1 flag_hi = 0;
      u_zvfs_ctrl_model.run_cycle(thr[s], 1'b1);
      #1 check(8'(flag_hi), 8'(WID));
      flag_hi = 0;
      u_zvfs_ctrl_model.run_cycle(thr[s] - 1, 1'b1);
      #1 check(8'(flag_hi), 8'h00);
    end
  endtask
  // Drain positive at turn-on, then reset again
  task automatic t_hard();
    flag_hi = 0;
    u_zvfs_ctrl_model.run_cycle(thr[3], 1'b0);
    #1 check(8'(flag_hi), 8'h00);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({5'h0, gdrv, flag, flt_oe_n}, 8'h00);
    // Release with clock enable low: sequencer must stay frozen
    @(posedge clk) begin
      rst_n <= 1'b1;
      en <= 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 check({6'h0, build, flt_oe_n}, 8'h00);
    @(posedge clk) en <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({7'h0, flt_oe_n}, 8'h01);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_startup();
    t_strength();
    t_hard();
    close_out();
  end
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule
